// >>> core/eai_loader.sv
// Image auto-init loader with checksum, read-back check and start logic.
// Assumes a classic Wishbone master, a same-clock RAM with one-cycle
// read latency on the mem_* port, and a serial memory on spi_* pins.
module eai_loader import eai_pkg::*; #(
  parameter int IMAGE_WORDS = IMAGE_WORDS_DEF,
  parameter int DIV = SPI_HALF_CYC
) (
  input wire logic mclk, // Device clock, 100 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic ce, // Clock enable, freezes state
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [3:0] wb_sel_i, // Byte lanes
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic auto_init_enable_pin, // Auto-init enable strap
  input wire logic [4:0] rt_addr_pin, // Terminal address pins
  input wire logic rt_par_pin, // Address parity pin
  input wire logic addr_lock_pin, // Address lock strap
  output logic ready, // Device ready
  output logic irq, // Interrupt request
  output logic mem_we, // RAM write strobe
  output logic [12:0] mem_addr, // RAM word address
  output logic [15:0] mem_wdata, // RAM write data
  input wire logic [15:0] mem_rdata, // RAM read data, one cycle late
  output logic spi_sck, // Serial clock
  output logic spi_cs_n, // Serial select, active low
  output logic spi_mosi, // Serial data out
  input wire logic spi_miso // Serial data in
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  eai_spi_if spi (); // Byte stream link
  eai_state_e st_q; // Loader state
  logic [7:0] pin_s1_q, pin_s2_q; // Strap synchroniser
  logic [4:0] strap_cnt_q; // Delay after reset release
  logic auto_q; // Latched enable strap
  logic lock_q; // Latched lock strap
  logic loaded_q; // An image was loaded
  logic [12:0] addr_q; // Current word address
  logic [7:0] hi_q; // Upper byte of word
  logic [15:0] word_q; // Assembled image word
  logic [15:0] sum_q; // Running checksum tally
  logic [15:0] csum_img_q; // Stored checksum from image
  logic img_exec_q, img_ena_q; // Image start and enable bits
  logic [15:0] cfg1_q; // Master config one
  logic [15:0] op_q; // Terminal operational status
  logic ckf_q, rbf_q; // Status error flags
  logic hwp_rbf_q; // Pending read-back flag
  logic lfail_q; // Load fail in BIT word
  logic [12:0] fail_addr_q; // First mismatch address
  logic ack_q; // Bus acknowledge
  logic [31:0] dat_q; // Bus read data
  logic apf; // Address parity fail
  logic wr_go, rd_go; // Bus access taken
  logic [5:0] idx; // Register index
  logic [15:0] wd; // Written half word
  logic excl; // Location left out of sum
  logic is_cfg1, is_opst, is_mem; // Location kinds
  logic chk; // Location is verified
  logic [15:0] rbv, expv; // Read-back and expected
  logic soft_go; // Soft reset request
  logic w_stat; // Status write
  logic start_ok; // Self-start allowed
  logic last; // Last image word
  logic irq_q_w; // Error interrupt pending
  assign idx = wb_adr_i[7:2];
  assign wd = wb_dat_i[15:0];
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q
    & (&wb_sel_i[1:0]);
  assign rd_go = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;
  assign w_stat = wr_go & (idx == IDX_STAT) & ready;
  assign soft_go = w_stat & wd[B_SOFT];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq = ready & irq_q_w;
  // Odd parity over latched address and parity
  assign apf = ~(^op_q[15:B_PAR]);
  assign is_cfg1 = (addr_q == {7'h00, IDX_CFG1});
  assign is_opst = (addr_q == {7'h00, IDX_OPST});
  assign is_mem = (addr_q != {7'h00, IDX_CFG1})
    & (addr_q != {7'h00, IDX_STAT}) & (addr_q != {7'h00, IDX_HWP})
    & (addr_q != {7'h00, IDX_OPST}) & (addr_q != {7'h00, IDX_BITW})
    & (addr_q != {7'h00, IDX_FAIL});
  assign excl = (addr_q >= CSUM_EXCL_LO) & (addr_q <= CSUM_EXCL_HI);
  // Op status loaded from the image only when lock was low
  assign chk = is_mem | is_cfg1 | (is_opst & ~lock_q);
  assign last = (addr_q == 13'(IMAGE_WORDS - 1));
  // Both image bits, good parity, clean load
  assign start_ok = img_exec_q & img_ena_q & ~apf & ~rbf_q
    & (sum_q == ZERO16);
  ////////////////////////////////////////////////////////////////////////
  // Read-back mux for verify
  always_comb begin
    rbv = mem_rdata;
    expv = word_q;
    if (is_cfg1) begin
      // Execute start is held low during load
      rbv = cfg1_q & ~(16'h0001 << B_EXEC);
      expv = word_q & ~(16'h0001 << B_EXEC);
    end else if (is_opst) begin
      rbv = op_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Serial reader
  eai_spi_rd #(.DIV(DIV)) u_rd (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .bus(spi),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso)
  );
  ////////////////////////////////////////////////////////////////////////
  // Strap pin synchroniser
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else if (ce) begin
      pin_s1_q <= {auto_init_enable_pin, addr_lock_pin, rt_par_pin,
        rt_addr_pin};
      pin_s2_q <= pin_s1_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Loader sequence
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= EAI_STRAP;
      strap_cnt_q <= 5'h00;
      auto_q <= 1'b0;
      lock_q <= 1'b0;
      loaded_q <= 1'b0;
      addr_q <= 13'h0000;
      hi_q <= 8'h00;
      word_q <= ZERO16;
      sum_q <= ZERO16;
      csum_img_q <= ZERO16;
      img_exec_q <= 1'b0;
      img_ena_q <= 1'b0;
      spi.start <= 1'b0;
      spi.stop <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 13'h0000;
      mem_wdata <= ZERO16;
      ready <= 1'b0;
    end else if (ce) begin
      spi.start <= 1'b0;
      spi.stop <= 1'b0;
      mem_we <= 1'b0;
      case (st_q)
        EAI_STRAP: begin
          // Wait the strap delay, then latch the straps
          strap_cnt_q <= strap_cnt_q + 5'h01;
          if (strap_cnt_q == 5'(STRAP_CYC - 1)) begin
            auto_q <= pin_s2_q[7];
            lock_q <= pin_s2_q[6];
            // Load only with enable strap high
            st_q <= pin_s2_q[7] ? EAI_SPI : EAI_END;
          end
        end
        EAI_SPI: begin
          // Ready held low through the load
          ready <= 1'b0;
          addr_q <= 13'h0000;
          sum_q <= ZERO16;
          loaded_q <= 1'b1;
          spi.start <= 1'b1;
          st_q <= EAI_HI;
        end
        EAI_HI: begin
          // Even byte is the upper half
          if (spi.byte_vld) begin
            hi_q <= spi.byte_dat;
            st_q <= EAI_LO;
          end
        end
        EAI_LO: begin
          if (spi.byte_vld) begin
            word_q <= {hi_q, spi.byte_dat};
            // Write now so the RAM holds it before the read-back
            mem_addr <= addr_q;
            mem_wdata <= {hi_q, spi.byte_dat};
            mem_we <= is_mem;
            st_q <= EAI_WR;
          end
        end
        EAI_WR: begin
          if (is_cfg1) begin
            img_exec_q <= word_q[B_EXEC];
            img_ena_q <= word_q[B_ENA];
          end
          if (addr_q == A_CSUM) begin
            csum_img_q <= word_q;
          end
          // Add stored checksum and each value outside 0x0030 to 0x0048
          if (!excl) begin
            sum_q <= sum_q + word_q;
          end
          st_q <= EAI_RB;
        end
        EAI_RB: begin
          // RAM read data arrives next cycle
          st_q <= EAI_CMP;
        end
        EAI_CMP: begin
          if (last) begin
            spi.stop <= 1'b1;
            st_q <= EAI_END;
          end else begin
            addr_q <= addr_q + 13'h0001;
            st_q <= EAI_HI;
          end
        end
        EAI_END: begin
          // Stored checksum into its RAM word
          if (loaded_q) begin
            mem_we <= 1'b1;
            mem_addr <= A_CSUM;
            mem_wdata <= csum_img_q;
          end
          ready <= 1'b1;
          st_q <= EAI_FLAG;
        end
        EAI_FLAG: begin
          st_q <= EAI_READY;
        end
        EAI_READY: begin
          if (soft_go) begin
            ready <= 1'b0;
            st_q <= auto_q ? EAI_SPI : EAI_END;
          end
        end
        default: begin
          st_q <= EAI_STRAP;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Read-back failure flag and first fail address
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rbf_q <= 1'b0;
      fail_addr_q <= 13'h0000;
    end else if (ce) begin
      if (st_q == EAI_SPI) begin
        rbf_q <= 1'b0;
      end else if (st_q == EAI_CMP && chk && !rbf_q && rbv != expv) begin
        // Only the first one is logged
        rbf_q <= 1'b1;
        fail_addr_q <= addr_q;
      end else if (w_stat && wd[B_RBF] && st_q != EAI_FLAG) begin
        rbf_q <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Error flags raised after ready
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ckf_q <= 1'b0;
      hwp_rbf_q <= 1'b0;
      lfail_q <= 1'b0;
      irq_q_w <= 1'b0;
    end else if (ce) begin
      if (st_q == EAI_FLAG && loaded_q) begin
        ckf_q <= ckf_q | (sum_q != ZERO16);
        hwp_rbf_q <= hwp_rbf_q | rbf_q;
        lfail_q <= lfail_q | rbf_q | (sum_q != ZERO16);
        irq_q_w <= irq_q_w | rbf_q | (sum_q != ZERO16);
      end else begin
        if (soft_go) begin
          lfail_q <= 1'b0;
        end
        if (w_stat && wd[B_CKF]) begin
          ckf_q <= 1'b0;
        end
        if (wr_go && idx == IDX_HWP && wd[B_HWP_RBF] && ready) begin
          hwp_rbf_q <= 1'b0;
        end
        if (w_stat && (wd[B_CKF] || wd[B_RBF])) begin
          irq_q_w <= 1'b0;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Master config one
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg1_q <= CFG1_RST;
    end else if (ce) begin
      if (st_q == EAI_WR && is_cfg1) begin
        // Image word never sets execute start; start_ok sets it at the end
        cfg1_q <= word_q & ~(16'h0001 << B_EXEC);
      end else if (st_q == EAI_END && loaded_q) begin
        cfg1_q[B_EXEC] <= start_ok;
      end else if (soft_go) begin
        cfg1_q[B_EXEC] <= 1'b0;
      end else if (wr_go && idx == IDX_CFG1 && ready) begin
        cfg1_q <= wd;
        // Load errors do not block the host
        cfg1_q[B_EXEC] <= wd[B_EXEC] & wd[B_ENA] & ~apf;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Terminal operational status
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      op_q <= ZERO16;
    end else if (ce) begin
      if (st_q == EAI_STRAP && strap_cnt_q == 5'(STRAP_CYC - 1)) begin
        // Pins latched after the strap delay
        op_q <= {pin_s2_q[4:0], pin_s2_q[5], 1'b0, pin_s2_q[6], 8'h00};
      end else if (st_q == EAI_WR && is_opst && !lock_q) begin
        op_q <= word_q;
      end else if (wr_go && idx == IDX_OPST && ready) begin
        op_q <= wd;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, unmapped reads as zero once ready
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else if (ce) begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      if (rd_go) begin
        dat_q <= 32'h00000000;
        if (!ready) begin
          // Not ready: every read shows the status word
          dat_q[15:0] <= {auto_q, 13'h0000, ckf_q, rbf_q};
        end else begin
          case (idx)
            IDX_CFG1: dat_q[15:0] <= cfg1_q;
            IDX_STAT: dat_q[15:0] <= {auto_q, 13'h0000, ckf_q, rbf_q};
            IDX_HWP: dat_q[15:0] <= {2'b00, hwp_rbf_q, 9'h000, apf,
              3'b000};
            IDX_OPST: dat_q[15:0] <= op_q;
            IDX_BITW: dat_q[15:0] <= {15'h0000, lfail_q};
            IDX_FAIL: dat_q[15:0] <= {3'b000, fail_addr_q};
            default: dat_q <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule : eai_loader

// >>> core/eai_pkg.sv
// Constants for the image auto-init loader and its serial reader.
// Assumes one 100 MHz clock; a byte-wide serial memory holds the image.
package eai_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CFG1 = 6'h00;
  localparam logic [5:0] IDX_STAT = 6'h01;
  localparam logic [5:0] IDX_HWP = 6'h06;
  localparam logic [5:0] IDX_OPST = 6'h18;
  localparam logic [5:0] IDX_BITW = 6'h1E;
  localparam logic [5:0] IDX_FAIL = 6'h24;
  // Image word locations
  localparam logic [12:0] A_CSUM = 13'h0051;
  localparam logic [12:0] CSUM_EXCL_LO = 13'h0030;
  localparam logic [12:0] CSUM_EXCL_HI = 13'h0048;
  localparam int IMAGE_WORDS_DEF = 8192;
  ////////////////////////////////////////////////////////////////////////
  // Bit positions
  localparam int B_EXEC = 4;
  localparam int B_ENA = 6;
  localparam int B_RBF = 0;
  localparam int B_CKF = 1;
  localparam int B_SOFT = 10;
  localparam int B_AUTO = 15;
  localparam int B_HWP_APF = 3;
  localparam int B_HWP_RBF = 13;
  localparam int B_LFAIL = 0;
  localparam int B_LOCK = 8;
  localparam int B_PAR = 10;
  localparam int B_RTA = 11;
  localparam logic [15:0] CFG1_RST = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS = 10;
  localparam int STRAP_NS = 200;
  localparam int STRAP_CYC = (STRAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SPI_HALF_CYC = 4;
  localparam logic [7:0] SPI_CMD_READ = 8'h03;
  // Loader states
  typedef enum logic [3:0] {
    EAI_STRAP, EAI_SPI, EAI_HI, EAI_LO, EAI_WR, EAI_RB, EAI_CMP,
    EAI_END, EAI_FLAG, EAI_READY
  } eai_state_e;
endpackage : eai_pkg

// >>> core/eai_spi_if.sv
// Byte stream link between the loader and the serial reader.
// Assumes both ends run on the same clock.
interface eai_spi_if;
  logic start; // Pulse: begin read at byte 0
  logic stop; // Pulse: end read, release select
  logic byte_vld; // Pulse: a byte arrived
  logic [7:0] byte_dat; // Arrived byte
  modport ld (output start, stop, input byte_vld, byte_dat);
  modport rd (input start, stop, output byte_vld, byte_dat);
endinterface : eai_spi_if

// >>> core/eai_spi_rd.sv
// Serial memory reader: read command at address 0, then byte stream.
// Assumes a mode 0 memory that shifts data out on falling clock edges.
module eai_spi_rd import eai_pkg::*; #(
  parameter int DIV = SPI_HALF_CYC
) (
  input wire logic mclk, // Device clock
  input wire logic arst_n, // Async reset, active low
  input wire logic ce, // Clock enable
  eai_spi_if.rd bus, // Byte stream to loader
  output logic spi_sck, // Serial clock out
  output logic spi_cs_n, // Chip select, active low
  output logic spi_mosi, // Serial data out
  input wire logic spi_miso // Serial data in
);
  logic miso_s1_q, miso_s2_q; // Input synchroniser
  logic run_q; // Transfer active
  logic hdr_q; // Sending command and address
  logic [7:0] div_q; // Half period counter
  logic [4:0] cnt_q; // Bit counter
  logic [23:0] sr_q; // Outgoing shift register
  logic [7:0] in_q; // Incoming bits
  logic fall; // Falling clock edge this cycle
  assign fall = run_q & spi_sck & (div_q == 8'(DIV - 1));
  assign spi_mosi = sr_q[23];
  ////////////////////////////////////////////////////////////////////////
  // Two flops before the data line is used
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else if (ce) begin
      miso_s1_q <= spi_miso;
      miso_s2_q <= miso_s1_q;
    end
  end
  // Clock divider, shifting and byte assembly
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
      hdr_q <= 1'b0;
      div_q <= 8'h00;
      cnt_q <= 5'h00;
      sr_q <= 24'h000000;
      in_q <= 8'h00;
      spi_sck <= 1'b0;
      spi_cs_n <= 1'b1;
      bus.byte_vld <= 1'b0;
      bus.byte_dat <= 8'h00;
    end else if (ce) begin
      bus.byte_vld <= 1'b0;
      if (bus.start) begin
        run_q <= 1'b1;
        hdr_q <= 1'b1;
        div_q <= 8'h00;
        cnt_q <= 5'h00;
        sr_q <= {SPI_CMD_READ, 16'h0000};
        spi_sck <= 1'b0;
        spi_cs_n <= 1'b0;
      end else if (bus.stop) begin
        run_q <= 1'b0;
        spi_sck <= 1'b0;
        spi_cs_n <= 1'b1;
      end else if (run_q) begin
        if (div_q == 8'(DIV - 1)) begin
          div_q <= 8'h00;
          spi_sck <= ~spi_sck;
        end else begin
          div_q <= div_q + 8'h01;
        end
        if (fall && hdr_q) begin
          // Header bits leave on falling edges
          sr_q <= {sr_q[22:0], 1'b0};
          cnt_q <= (cnt_q == 5'd23) ? 5'h00 : cnt_q + 5'h01;
          hdr_q <= (cnt_q != 5'd23);
        end else if (fall) begin
          // Sample just before the falling edge
          in_q <= {in_q[6:0], miso_s2_q};
          cnt_q <= (cnt_q == 5'd7) ? 5'h00 : cnt_q + 5'h01;
          if (cnt_q == 5'd7) begin
            bus.byte_vld <= 1'b1;
            bus.byte_dat <= {in_q[6:0], miso_s2_q};
          end
        end
      end
    end
  end
endmodule : eai_spi_rd

// >>> verification/eai_eeprom_model.sv
// Serial memory model holding the init image; read command only.
// Assumes mode 0: sample on rising sck, shift out on falling sck.
module eai_eeprom_model (
  input wire logic spi_sck, // Serial clock
  input wire logic spi_cs_n, // Select, active low
  input wire logic spi_mosi, // Command in
  output logic spi_miso // Data out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256]; // Image bytes, filled by the bench
  logic [23:0] hdr = 24'h000000; // Command and start address
  logic o = 1'b0; // Last bit shifted out
  int cnt = 0; // Rising edges in this frame
  int k = 0; // Data bit index
  ////////////////////////////////////////////////////////////////////////
  // Frame start clears the count
  always @(negedge spi_cs_n) cnt = 0;
  // Command and address in, MSB first
  always @(posedge spi_sck) begin
    if (!spi_cs_n && cnt < 24) hdr = {hdr[22:0], spi_mosi};
    if (!spi_cs_n) cnt++;
  end
  always @(negedge spi_sck) begin
    if (!spi_cs_n && cnt >= 24 && hdr[23:16] == 8'h03) begin
      k = cnt - 24;
      o = mem[8'(hdr[15:0] + 16'(k / 8))][7 - k % 8];
    end
  end
  // Released line shows the inverse of the last bit
  assign spi_miso = spi_cs_n ? ~o : o;
endmodule : eai_eeprom_model

// >>> verification/eai_loader_sva.sv
// Checker bound to the loader top module.
// Assumes one clock domain with an async active-low reset.
module eai_loader_sva import eai_pkg::*; #(
  parameter int IMAGE_WORDS = IMAGE_WORDS_DEF
) (
  input wire logic mclk, // Clock
  input wire logic arst_n, // Reset
  input wire logic auto_init_enable_pin, // Strap
  input wire logic ready, // Ready
  input wire logic irq, // Interrupt
  input wire logic mem_we, // RAM write
  input wire logic [12:0] mem_addr, // RAM address
  input wire logic spi_sck, // Serial clock
  input wire logic spi_cs_n // Serial select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic load_q; // A load ran
  logic csum_q; // Checksum word written
  logic seen_q; // A word written in this frame
  logic [12:0] last_q; // Last written word
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  // Load tracking except last_q, cleared once ready
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      load_q <= 1'b0;
      csum_q <= 1'b0;
      seen_q <= 1'b0;
      last_q <= 13'h0000;
    end else if (ready) begin
      load_q <= 1'b0;
      csum_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      if (!spi_cs_n) load_q <= 1'b1;
      if (mem_we && mem_addr == A_CSUM) csum_q <= 1'b1;
      if (mem_we && !spi_cs_n) begin
        seen_q <= 1'b1;
        last_q <= mem_addr;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_load_not_ready: assert property (!spi_cs_n |-> !ready)
    else $error("ready high while loading");
  a_mem_quiet: assert property (ready && $past(ready) |-> !mem_we)
    else $error("RAM written after ready");
  a_irq_needs_ready: assert property (irq |-> ready && $past(ready))
    else $error("irq without settled ready");
  a_irq_after_ready: assert property (
    $rose(irq) |-> $past(ready) && !$past(ready, 2))
    else $error("irq not one cycle after ready");
  a_csum_at_ready: assert property (
    $rose(ready) && load_q |-> csum_q || (mem_we && mem_addr == A_CSUM))
    else $error("checksum word not stored");
  a_strap_off: assert property (!auto_init_enable_pin |-> spi_cs_n)
    else $error("load with strap low");
  a_word_range: assert property (mem_we |-> mem_addr < IMAGE_WORDS)
    else $error("write beyond image");
  a_addr_ascend: assert property (
    seen_q && mem_we && !spi_cs_n |-> mem_addr > last_q)
    else $error("words not ascending");
  a_sck_idle: assert property (
    spi_cs_n && $past(spi_cs_n) |-> !spi_sck)
    else $error("sck moves outside frame");
endmodule : eai_loader_sva

bind eai_loader eai_loader_sva #(.IMAGE_WORDS(IMAGE_WORDS)) i_eai_loader_sva (
  .mclk, .arst_n, .auto_init_enable_pin, .ready, .irq, .mem_we, .mem_addr,
  .spi_sck, .spi_cs_n
);

// >>> verification/tb.sv
// Bench for the image loader: rows of images, then hand-written cases.
// Assumes the serial memory model and a same-clock RAM built here.
module tb import eai_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WORDS = 84; // Short image up to word 0x0053
  localparam int LIMIT = 95000; // Cycle ceiling
  typedef struct packed {
    logic [15:0] cfg; // Image config word
    logic lock; // Lock strap
    logic [5:0] pins; // Address and parity pins
    logic [12:0] bad; // First of two RAM words that store wrong
    logic ck; // Spoil the checksum
  } eai_row_s;
  logic mclk = 1'b0, arst_n = 1'b0; // Clock, reset
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0; // Bus request
  logic [7:0] wb_adr_i = 8'h00; // Byte address
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o; // Bus data
  logic wb_ack_o, ready, irq, mem_we; // Design outputs
  logic spi_sck, spi_cs_n, spi_mosi, spi_miso; // Serial pins
  logic auto_init_enable_pin = 1'b0, rt_par_pin = 1'b0; // Straps
  logic addr_lock_pin = 1'b0; // Lock strap
  logic [4:0] rt_addr_pin = 5'h00; // Address pins
  logic [12:0] mem_addr, bad = 13'h1000; // RAM address, bad word
  logic [15:0] mem_wdata, mem_rdata = 16'h0000, csum; // RAM data
  logic [15:0] ram [8192]; // RAM behind the loader
  int n_fail = 0, check_count = 0, cycles = 0; // Counters
  eai_row_s rows [5] = '{
    '{16'h0050, 1'b0, 6'h06, 13'h1000, 1'b0}, // Self-start
    '{16'h0040, 1'b0, 6'h06, 13'h1000, 1'b0}, // No start bit
    '{16'h0050, 1'b0, 6'h06, 13'h0052, 1'b0}, // Read-back faults
    '{16'h0050, 1'b0, 6'h06, 13'h1000, 1'b1}, // Bad checksum
    '{16'h0050, 1'b1, 6'h06, 13'h1000, 1'b0}}; // Locked, bad parity
  eai_loader #(.IMAGE_WORDS(WORDS), .DIV(4)) i_eai_loader (
    .mclk, .arst_n, .ce(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i(4'hF), .wb_dat_o, .wb_ack_o, .auto_init_enable_pin,
    .rt_addr_pin, .rt_par_pin, .addr_lock_pin, .ready, .irq, .mem_we,
    .mem_addr, .mem_wdata, .mem_rdata, .spi_sck, .spi_cs_n, .spi_mosi,
    .spi_miso);
  eai_eeprom_model i_eai_eeprom_model (.spi_sck, .spi_cs_n, .spi_mosi,
    .spi_miso);
  ////////////////////////////////////////////////////////////////////////
  // Clock and RAM with one-cycle read; bad words store inverted
  always #5 mclk = ~mclk;
  always_ff @(posedge mclk) begin
    if (mem_we) ram[mem_addr] <= (mem_addr == bad ||
      mem_addr == bad + 13'h0001) ? ~mem_wdata : mem_wdata;
    mem_rdata <= ram[mem_addr];
  end
  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      n_fail++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle, held until ack
  task automatic wb(input logic w, input logic [5:0] i, input logic [15:0] d,
                    output logic [15:0] q);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, i, d, q);
  endtask : wr
  task automatic rd_chk(input logic [5:0] i, input logic [15:0] m,
                        input logic [15:0] e);
    logic [15:0] q;
    wb(1'b0, i, 16'h0000, q);
    chk(q & m, e);
  endtask : rd_chk
  // Image with its two's complement sum
  task automatic build(input logic [15:0] cfg, input logic ck);
    logic [15:0] w [WORDS];
    logic [15:0] s;
    s = 16'h0000;
    for (int n = 0; n < WORDS; n++) begin
      w[n] = {~8'(n), 8'(n)};
      if (n == 0) w[n] = cfg;
      if (n == 24) w[n] = 16'h0400;
      if ((n < 16'h0030 || n > 16'h0048) && n != 16'h0051) s += w[n];
    end
    w[8'h51] = 16'h0000 - s;
    csum = w[8'h51];
    if (ck) w[8'h50] += 16'h0001;
    for (int n = 0; n < WORDS; n++) begin
      i_eai_eeprom_model.mem[2 * n] = w[n][15:8];
      i_eai_eeprom_model.mem[2 * n + 1] = w[n][7:0];
    end
  endtask : build
  task automatic start(input logic au, input logic lk, input logic [5:0] p);
    arst_n <= 1'b0;
    auto_init_enable_pin <= au;
    addr_lock_pin <= lk;
    {rt_addr_pin, rt_par_pin} <= p;
    repeat (5) @(posedge mclk);
    chk(16'(ready | irq), 16'h0000);
    arst_n <= 1'b1;
  endtask : start
  task automatic wait_ready;
    do begin
      @(posedge mclk);
    end while (ready !== 1'b1);
    repeat (3) @(posedge mclk);
  endtask : wait_ready
  task automatic run_row(input eai_row_s r);
    logic [5:0] op;
    logic rbf;
    logic apf;
    logic ex;
    bad = r.bad;
    build(r.cfg, r.ck);
    start(1'b1, r.lock, r.pins);
    wait_ready();
    op = r.lock ? r.pins : 6'h01;
    apf = ~^op;
    rbf = (r.bad != 13'h1000);
    ex = r.cfg[4] & r.cfg[6] & ~apf & ~rbf & ~r.ck;
    rd_chk(IDX_CFG1, 16'h0010, {11'h000, ex, 4'h0});
    rd_chk(IDX_STAT, 16'h8003, {1'b1, 13'h0000, r.ck, rbf});
    rd_chk(IDX_HWP, 16'h2008, {2'b00, rbf, 9'h000, apf, 3'h0});
    rd_chk(IDX_OPST, 16'hFC00, {op, 10'h000});
    rd_chk(IDX_BITW, 16'h0001, {15'h0000, rbf | r.ck});
    if (rbf) rd_chk(IDX_FAIL, 16'h1FFF, {3'h0, r.bad});
    chk(16'(irq), 16'(rbf | r.ck));
    chk(ram[13'h0051], csum);
    chk(ram[13'h004A], 16'hB54A);
  endtask : run_row
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 5; i++) run_row(rows[i]);
    // Parity fault still stands from the last row
    wr(IDX_CFG1, 16'h0050);
    rd_chk(IDX_CFG1, 16'h0010, 16'h0000);
    wr(IDX_OPST, 16'h1C00);
    wr(IDX_CFG1, 16'h0050);
    rd_chk(IDX_CFG1, 16'h0010, 16'h0010);
    // Read-back fault, host start, clear, reload
    run_row(rows[2]);
    wr(IDX_CFG1, 16'h0050);
    rd_chk(IDX_CFG1, 16'h0010, 16'h0010);
    wr(IDX_STAT, 16'h0003);
    wr(IDX_HWP, 16'h2000);
    rd_chk(IDX_STAT, 16'h0001, 16'h0000);
    chk(16'(irq), 16'h0000);
    // Reload faults at a new word, so the log must move
    bad = 13'h0050;
    wr(IDX_STAT, 16'h0400);
    chk(16'(ready), 16'h0000);
    wait_ready();
    rd_chk(IDX_STAT, 16'h0001, 16'h0001);
    rd_chk(IDX_FAIL, 16'h1FFF, 16'h0050);
    rd_chk(6'h3F, 16'hFFFF, 16'h0000);
    // Strap low: no load at all
    start(1'b0, 1'b0, 6'h01);
    wait_ready();
    rd_chk(IDX_STAT, 16'h8000, 16'h0000);
    chk(16'({ready, spi_cs_n}), 16'h0003);
    report_and_stop();
  end
endmodule : tb
